// ### core/dcc_defines.svh
// Offsets, field positions, reset values and codes for one DMA channel.
// Assumes a 32-bit APB with byte addresses and one register per word.
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// Register byte addresses
`define DCC_CTRL_ADDR   32'h5000351C
`define DCC_SRC_ADDR    32'h50003600
`define DCC_DST_ADDR    32'h50003604
`define DCC_LEN_ADDR    32'h50003608
`define DCC_ICNT_ADDR   32'h5000360C
`define DCC_IDX_ADDR    32'h50003610
`define DCC_STAT_ADDR   32'h50003614
`define DCC_CLR_ADDR    32'h50003618
`define DCC_IEN_ADDR    32'h5000361C

// Control register fields
`define DCC_CTRL_W      14
`define DCC_CTRL_RST    14'h0000
`define DCC_F_ON        0
`define DCC_F_BW_LO     1
`define DCC_F_BW_HI     2
`define DCC_F_IRQEN     3
`define DCC_F_TRIG      4
`define DCC_F_DINC      5
`define DCC_F_SINC      6
`define DCC_F_CIRC      7
`define DCC_F_PRIO_LO   8
`define DCC_F_PRIO_HI   10
`define DCC_F_SENSE     13

// Interrupt status bits
`define DCC_EV_W        2
`define DCC_EV_MATCH    0
`define DCC_EV_DONE     1

`define DCC_RST16       16'h0000
`define DCC_RST32       32'h00000000

`endif

// ### core/dcc_pkg.sv
// Types shared by the DMA channel control logic.
// Assumes the constants header is compiled alongside.
package dcc_pkg;

    typedef enum logic [1:0] {
        DCC_IDLE = 2'b00,
        DCC_ARB  = 2'b01,
        DCC_XFER = 2'b11
    } dcc_state_t;

    typedef enum logic [1:0] {
        DCC_BW_BYTE = 2'b00,
        DCC_BW_HALF = 2'b01,
        DCC_BW_WORD = 2'b10,
        DCC_BW_RSVD = 2'b11
    } dcc_width_t;

endpackage : dcc_pkg

// ### core/dcc_channel.sv
// One DMA channel: control register, item sequencing, arbitration, IRQ.
// Assumes an APB master, a bus engine that acknowledges each item with
// xfer_done_i, and the other channels' requests and priorities as inputs.
//
// Our own choice: the APB interface to the registers.
`include "dcc_defines.svh"

module dcc_channel
    import dcc_pkg::*;
#(
    parameter int NUM_CH = 4,
    parameter int CH_IDX = 1
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic periph_req_i,
    input wire logic [NUM_CH-1:0] other_req_i,
    input wire logic [3*NUM_CH-1:0] other_prio_i,
    output logic [NUM_CH-1:0] grant_o,
    output logic xfer_valid_o,
    output logic [31:0] src_addr_o,
    output logic [31:0] dst_addr_o,
    output logic [1:0] xfer_size_o,
    input wire logic xfer_done_i,
    output logic chan_on_o,
    output logic irq_o
);

    // Arbiter: ascending scan with strict compare keeps the lower index
    function automatic logic [NUM_CH-1:0] pick(
        input logic [NUM_CH-1:0] req,
        input logic [3*NUM_CH-1:0] prio
    );
        logic [NUM_CH-1:0] g;
        logic [2:0] best;
        logic found;
        g = '0;
        best = 3'h0;
        found = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (req[i] && (!found || prio[3*i +: 3] > best)) begin
                g = '0;
                g[i] = 1'b1;
                best = prio[3*i +: 3];
                found = 1'b1;
            end
        end
        return g;
    endfunction : pick

    // Byte step for one item
    function automatic logic [31:0] step_of(input logic [1:0] bw);
        case (bw)
            DCC_BW_BYTE: step_of = 32'h00000001;
            DCC_BW_HALF: step_of = 32'h00000002;
            DCC_BW_WORD: step_of = 32'h00000004;
            // Reserved code steps as a word rather than stalling the channel
            default: step_of = 32'h00000004;
        endcase
    endfunction : step_of

    // Software-visible registers
    logic [`DCC_CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [31:0] src_q, src_d;
    logic [31:0] dst_q, dst_d;
    logic [15:0] len_q, len_d;
    logic [15:0] icnt_q, icnt_d;
    logic [15:0] idx_q, idx_d;
    logic [`DCC_EV_W-1:0] stat_q, stat_d;
    logic [`DCC_EV_W-1:0] ien_q, ien_d;
    logic [31:0] rdata_q, rdata_d;
    logic slverr_q, slverr_d;
    // Sequencer and request tracking
    dcc_state_t state_q, state_d;
    logic pend_q, pend_d;
    logic req_prev_q;
    // Addresses of the item in flight
    logic [31:0] sa_q, sa_d;
    logic [31:0] da_q, da_d;

    // Control fields
    wire logic run = ctrl_q[`DCC_F_ON];
    wire logic [1:0] bw = ctrl_q[`DCC_F_BW_HI:`DCC_F_BW_LO];
    wire logic irq_en = ctrl_q[`DCC_F_IRQEN];
    wire logic trig = ctrl_q[`DCC_F_TRIG];
    wire logic dinc = ctrl_q[`DCC_F_DINC];
    wire logic sinc = ctrl_q[`DCC_F_SINC];
    wire logic circ = ctrl_q[`DCC_F_CIRC];
    wire logic [2:0] prio = ctrl_q[`DCC_F_PRIO_HI:`DCC_F_PRIO_LO];
    wire logic sense = ctrl_q[`DCC_F_SENSE];

    // APB decode
    wire logic setup = psel_i && !penable_i;
    wire logic access = psel_i && penable_i;
    wire logic wr = access && pwrite_i;
    wire logic hit_ctrl = paddr_i == `DCC_CTRL_ADDR;
    wire logic hit_src = paddr_i == `DCC_SRC_ADDR;
    wire logic hit_dst = paddr_i == `DCC_DST_ADDR;
    wire logic hit_len = paddr_i == `DCC_LEN_ADDR;
    wire logic hit_icnt = paddr_i == `DCC_ICNT_ADDR;
    wire logic hit_idx = paddr_i == `DCC_IDX_ADDR;
    wire logic hit_stat = paddr_i == `DCC_STAT_ADDR;
    wire logic hit_clr = paddr_i == `DCC_CLR_ADDR;
    wire logic hit_ien = paddr_i == `DCC_IEN_ADDR;
    wire logic hit_any = hit_ctrl | hit_src | hit_dst | hit_len | hit_icnt
                       | hit_idx | hit_stat | hit_clr | hit_ien;
    // Read-only registers refuse writes, the clear register refuses reads
    wire logic bad = !hit_any
                   || (pwrite_i && (hit_idx || hit_stat))
                   || (!pwrite_i && hit_clr);

    // Peripheral request: level, or latched rising edge
    wire logic rise = periph_req_i && !req_prev_q;
    wire logic preq = sense ? pend_q : periph_req_i;
    wire logic ready_item = run && (!trig || preq);

    // Arbitration among all channels, this one inserted at CH_IDX
    logic [NUM_CH-1:0] all_req;
    logic [3*NUM_CH-1:0] all_prio;
    always_comb begin
        all_req = other_req_i;
        all_prio = other_prio_i;
        all_req[CH_IDX] = state_q == DCC_ARB;
        all_prio[3*CH_IDX +: 3] = prio;
    end
    wire logic [NUM_CH-1:0] grant = pick(all_req, all_prio);
    wire logic won = grant[CH_IDX];

    // Item bookkeeping
    wire logic item_done = state_q == DCC_XFER && xfer_done_i;
    // Length holds the item count minus one
    wire logic last = idx_q == len_q;
    wire logic match = idx_q == icnt_q;
    wire logic wrap = circ && trig;
    // Addresses rebuilt from the index, so a wrap needs no rewind
    wire logic [31:0] step = step_of(bw);
    wire logic [31:0] off = idx_q * step;
    wire logic [31:0] nxt_sa = sinc ? src_q + off : src_q;
    wire logic [31:0] nxt_da = dinc ? dst_q + off : dst_q;
    // Fresh start drops any index left by a stopped transfer
    wire logic start = wr && hit_ctrl && pwdata_i[`DCC_F_ON] && !run;

    // Both events need the channel's interrupt enable
    wire logic [`DCC_EV_W-1:0] ev;
    assign ev[`DCC_EV_MATCH] = item_done && match && irq_en;
    assign ev[`DCC_EV_DONE] = item_done && last && irq_en;

    // Channel sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            DCC_IDLE: begin
                if (ready_item) begin
                    state_d = DCC_ARB;
                end
            end
            DCC_ARB: begin
                // A withdrawn level request also withdraws the bus request
                if (!ready_item) begin
                    state_d = DCC_IDLE;
                end else if (won) begin
                    state_d = DCC_XFER;
                end
            end
            DCC_XFER: begin
                if (xfer_done_i) begin
                    state_d = DCC_IDLE;
                end
            end
            default: state_d = DCC_IDLE;
        endcase
    end

    // Edge pending is consumed when the item wins the bus
    always_comb begin
        pend_d = pend_q;
        if (state_q == DCC_ARB && won) begin
            pend_d = 1'b0;
        end
        // A stopped channel forgets old edges, so a restart needs a new one
        if (!run) begin
            pend_d = 1'b0;
        end
        if (rise && sense && run) begin
            pend_d = 1'b1;
        end
    end

    // Item index and run bit; a software write beats a hardware clear
    always_comb begin
        idx_d = idx_q;
        ctrl_d = ctrl_q;
        if (item_done) begin
            if (last) begin
                idx_d = `DCC_RST16;
                if (!wrap) begin
                    ctrl_d[`DCC_F_ON] = 1'b0;
                end
            end else begin
                idx_d = idx_q + 16'h0001;
            end
        end
        if (start) begin
            idx_d = `DCC_RST16;
        end
        if (wr && hit_ctrl) begin
            ctrl_d = pwdata_i[`DCC_CTRL_W-1:0];
        end
    end

    // Other software registers
    always_comb begin
        src_d = (wr && hit_src) ? pwdata_i : src_q;
        dst_d = (wr && hit_dst) ? pwdata_i : dst_q;
        len_d = (wr && hit_len) ? pwdata_i[15:0] : len_q;
        icnt_d = (wr && hit_icnt) ? pwdata_i[15:0] : icnt_q;
        ien_d = (wr && hit_ien) ? pwdata_i[`DCC_EV_W-1:0] : ien_q;
        // New events win over a clear in the same cycle
        stat_d = stat_q;
        if (wr && hit_clr) begin
            stat_d = stat_q & ~pwdata_i[`DCC_EV_W-1:0];
        end
        stat_d = stat_d | ev;
    end

    // Item addresses are latched when the bus is won
    always_comb begin
        sa_d = sa_q;
        da_d = da_q;
        if (state_q == DCC_ARB && won) begin
            sa_d = nxt_sa;
            da_d = nxt_da;
        end
    end

    // Read data captured in setup so it comes from flip-flops
    always_comb begin
        rdata_d = rdata_q;
        slverr_d = slverr_q;
        if (setup) begin
            slverr_d = bad;
            case (1'b1)
                hit_ctrl: rdata_d = {18'h0, ctrl_q};
                hit_src: rdata_d = src_q;
                hit_dst: rdata_d = dst_q;
                hit_len: rdata_d = {16'h0000, len_q};
                hit_icnt: rdata_d = {16'h0000, icnt_q};
                hit_idx: rdata_d = {16'h0000, idx_q};
                hit_stat: rdata_d = {30'h0, stat_q};
                hit_ien: rdata_d = {30'h0, ien_q};
                default: rdata_d = `DCC_RST32;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            ctrl_q <= `DCC_CTRL_RST;
            src_q <= `DCC_RST32;
            dst_q <= `DCC_RST32;
            len_q <= `DCC_RST16;
            icnt_q <= `DCC_RST16;
            idx_q <= `DCC_RST16;
        end else begin
            ctrl_q <= ctrl_d;
            src_q <= src_d;
            dst_q <= dst_d;
            len_q <= len_d;
            icnt_q <= icnt_d;
            idx_q <= idx_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            stat_q <= '0;
            ien_q <= '0;
            rdata_q <= `DCC_RST32;
            slverr_q <= 1'b0;
            state_q <= DCC_IDLE;
            pend_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            ien_q <= ien_d;
            rdata_q <= rdata_d;
            slverr_q <= slverr_d;
            state_q <= state_d;
            pend_q <= pend_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            req_prev_q <= 1'b0;
            sa_q <= `DCC_RST32;
            da_q <= `DCC_RST32;
        end else begin
            req_prev_q <= periph_req_i;
            sa_q <= sa_d;
            da_q <= da_d;
        end
    end

    // Outputs
    assign prdata_o = rdata_q;
    // No wait states: read data was captured in the setup cycle
    assign pready_o = 1'b1;
    assign pslverr_o = access && slverr_q;
    assign grant_o = grant;
    assign xfer_valid_o = state_q == DCC_XFER;
    assign src_addr_o = sa_q;
    assign dst_addr_o = da_q;
    assign xfer_size_o = bw;
    assign chan_on_o = run;
    // Gating by the irq_en bit as well keeps a channel with irq_en clear silent; the run bit does not gate it
    assign irq_o = irq_en && |(stat_q & ien_q);

endmodule : dcc_channel

// ### dv/dcc_monitor.sv
// Checker for one DMA channel, bound to every dcc_channel.
// Assumes the default of four channels and one clock domain.
module dcc_monitor #(
    parameter int NUM_CH = 4,
    parameter int CH_IDX = 1
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [NUM_CH-1:0] other_req_i,
    input wire logic [3*NUM_CH-1:0] other_prio_i,
    input wire logic [NUM_CH-1:0] grant_o,
    input wire logic xfer_valid_o,
    input wire logic [31:0] src_addr_o,
    input wire logic [31:0] dst_addr_o,
    input wire logic xfer_done_i,
    input wire logic chan_on_o,
    input wire logic irq_o
);
    logic item_end;
    logic reg_wr;
    assign item_end = xfer_valid_o && xfer_done_i;
    assign reg_wr = psel_i && penable_i && pwrite_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    grant_high_a: assert property (other_req_i[2] && other_req_i[3] &&
        other_prio_i[11:9] > other_prio_i[8:6] |-> !grant_o[2]) else $error("low prio won");
    grant_tie_a: assert property (other_req_i[0] && other_req_i[2] &&
        other_prio_i[2:0] == other_prio_i[8:6] |-> !grant_o[2]) else $error("tie order");
    win_first_a: assert property ($rose(xfer_valid_o) |-> $past(grant_o[CH_IDX]))
        else $error("item without grant");
    addr_hold_a: assert property (xfer_valid_o && !xfer_done_i |=> xfer_valid_o &&
        $stable(src_addr_o) && $stable(dst_addr_o)) else $error("item address moved");
    item_end_a: assert property (item_end |=> !xfer_valid_o)
        else $error("item not closed");
    run_clear_a: assert property ($fell(chan_on_o) |-> $past(item_end) || $past(reg_wr))
        else $error("run bit dropped");
    off_quiet_a: assert property (!chan_on_o && !xfer_valid_o |=> !xfer_valid_o)
        else $error("idle channel moved");
    irq_cause_a: assert property ($rose(irq_o) |-> $past(item_end) || $past(reg_wr))
        else $error("stray interrupt");
    cover property ($rose(xfer_valid_o));
    cover property ($rose(irq_o));
    cover property (grant_o[0] && other_req_i[2]);
endmodule : dcc_monitor

bind dcc_channel dcc_monitor #(.NUM_CH(NUM_CH), .CH_IDX(CH_IDX)) mon (.ref_clk_i, .reset_n_i,
    .psel_i, .penable_i, .pwrite_i, .other_req_i, .other_prio_i, .grant_o, .xfer_valid_o,
    .src_addr_o, .dst_addr_o, .xfer_done_i, .chan_on_o, .irq_o);

// ### dv/dcc_bus_model.sv
// Bus engine stand-in: acknowledges each item after lat_i extra cycles.
// Assumes the channel holds xfer_valid until it samples the acknowledge.
module dcc_bus_model (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic xfer_valid_i,
    input wire logic [1:0] lat_i,
    output logic xfer_done_o
);
    logic [1:0] cnt_q;
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            cnt_q <= 2'h0;
            xfer_done_o <= 1'b0;
        end else begin
            // One-cycle pulse, so an item is never acknowledged twice
            xfer_done_o <= 1'b0;
            cnt_q <= 2'h0;
            if (xfer_valid_i && !xfer_done_o) begin
                xfer_done_o <= (cnt_q == lat_i);
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end
endmodule : dcc_bus_model

// ### dv/dma_channel_control_tb.sv
// Testbench for one DMA channel: APB tasks, an item log and a bus engine model.
// Assumes the design defaults of four channels, this one at index one.
`include "dcc_defines.svh"
module dma_channel_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic periph_req_i = 0, xfer_done_i, pready_o, pslverr_o, xfer_valid_o, chan_on_o, irq_o;
    logic [31:0] paddr_i = 0, pwdata_i = 0, prdata_o, src_addr_o, dst_addr_o, rd, sq[$], dq[$];
    logic [3:0] other_req_i = 0, grant_o;
    logic [11:0] other_prio_i = 0;
    logic [1:0] xfer_size_o, lat_i = 0;
    logic err;
    int num_errors = 0;
    int n_tests = 0;
    dcc_channel dut (.ref_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .periph_req_i, .other_req_i,
        .other_prio_i, .grant_o, .xfer_valid_o, .src_addr_o, .dst_addr_o, .xfer_size_o,
        .xfer_done_i, .chan_on_o, .irq_o);
    dcc_bus_model bus (.ref_clk_i, .reset_n_i, .xfer_valid_i(xfer_valid_o), .lat_i,
        .xfer_done_o(xfer_done_i));
    initial forever #25 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) if (xfer_valid_o && xfer_done_i) begin
        sq.push_back(src_addr_o);
        dq.push_back(dst_addr_o);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc
    task automatic run(input logic [31:0] c);
        sq.delete();
        dq.delete();
        apb(1'b1, `DCC_CTRL_ADDR, c);
        repeat (2) @(posedge ref_clk_i);
        for (int k = 0; k < 200 && chan_on_o === 1'b1; k++) @(posedge ref_clk_i);
        repeat (3) @(posedge ref_clk_i);
    endtask : run
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        num_errors++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        rdc(`DCC_CTRL_ADDR, 32'h0);
        // Run bit low with immediate trigger: nothing may move
        apb(1'b1, `DCC_CTRL_ADDR, 32'h3F6C);
        rdc(`DCC_CTRL_ADDR, 32'h3F6C);
        repeat (10) @(posedge ref_clk_i);
        chk(sq.size(), 0);
        apb(1'b0, 32'h50003700, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, `DCC_IDX_ADDR, 32'h5);
        chk(err, 1'b1);
        rdc(`DCC_IDX_ADDR, 32'h0);
        apb(1'b1, `DCC_SRC_ADDR, 32'h1000);
        apb(1'b1, `DCC_DST_ADDR, 32'h2000);
        apb(1'b1, `DCC_LEN_ADDR, 32'h2);
        other_req_i <= 4'b1000;
        other_prio_i <= 12'hE00;
        // Software keeps to the documented widths, never code 11
        for (int w = 0; w < 3; w++) begin
            run(32'h741 | (w << 1) | ((w != 1) ? 32'h20 : 32'h0));
            chk(sq.size(), 3);
            chk(xfer_size_o, w);
            for (int i = 0; i < 3; i++) begin
                chk(sq[i], 32'h1000 + (i << w));
                chk(dq[i], (w != 1) ? 32'h2000 + (i << w) : 32'h2000);
            end
            chk(chan_on_o, 1'b0);
            rdc(`DCC_IDX_ADDR, 32'h0);
        end
        other_req_i <= 4'b0;
        lat_i <= 2'd2;
        apb(1'b1, `DCC_ICNT_ADDR, 32'h1);
        apb(1'b1, `DCC_IEN_ADDR, 32'h1);
        run(32'h9);
        chk(irq_o, 1'b1);
        rdc(`DCC_STAT_ADDR, 32'h3);
        apb(1'b1, `DCC_CLR_ADDR, 32'h1);
        @(negedge ref_clk_i);
        chk(irq_o, 1'b0);
        rdc(`DCC_STAT_ADDR, 32'h2);
        apb(1'b1, `DCC_IEN_ADDR, 32'h2);
        @(negedge ref_clk_i);
        chk(irq_o, 1'b1);
        apb(1'b1, `DCC_CTRL_ADDR, 32'h0);
        @(negedge ref_clk_i);
        chk(irq_o, 1'b0);
        apb(1'b1, `DCC_CTRL_ADDR, 32'h8);
        @(negedge ref_clk_i);
        chk(irq_o, 1'b1);
        apb(1'b1, `DCC_IEN_ADDR, 32'h0);
        @(negedge ref_clk_i);
        chk(irq_o, 1'b0);
        apb(1'b1, `DCC_CLR_ADDR, 32'h3);
        run(32'h1);
        rdc(`DCC_STAT_ADDR, 32'h0);
        apb(1'b1, `DCC_LEN_ADDR, 32'h1);
        sq.delete();
        apb(1'b1, `DCC_CTRL_ADDR, 32'hD1);
        repeat (20) @(posedge ref_clk_i);
        chk(sq.size(), 0);
        periph_req_i <= 1'b1;
        repeat (60) @(posedge ref_clk_i);
        chk(sq.size() >= 4, 1);
        chk(chan_on_o, 1'b1);
        chk(sq[1], 32'h1001);
        chk(sq[2], 32'h1000);
        periph_req_i <= 1'b0;
        run(32'h0);
        periph_req_i <= 1'b1;
        apb(1'b1, `DCC_LEN_ADDR, 32'h0);
        sq.delete();
        apb(1'b1, `DCC_CTRL_ADDR, 32'h2011);
        repeat (20) @(posedge ref_clk_i);
        chk(sq.size(), 0);
        periph_req_i <= 1'b0;
        @(posedge ref_clk_i);
        periph_req_i <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        chk(sq.size(), 1);
        chk(chan_on_o, 1'b0);
        other_req_i <= 4'b1101;
        other_prio_i <= {3'd7, 3'd5, 3'd0, 3'd5};
        @(negedge ref_clk_i);
        chk(grant_o, 4'b1000);
        @(posedge ref_clk_i);
        other_prio_i <= {3'd5, 3'd5, 3'd0, 3'd5};
        @(negedge ref_clk_i);
        chk(grant_o, 4'b0001);
        close_out();
    end
endmodule : dma_channel_control_tb
